// ---- hw/rscc_top.v ----
// reset source collection and system clock control with an apb register port
//
// Behaviour
// RQ1: while reset pin is low, hold pins, core and all registers in reset
// RQ2: on reset pin release, pulse a start-from-reset-vector request
// RQ3: after any reset, processor clock is low-speed on-chip clock divided by eight; oscillation-stop reset keeps the second source bit instead
// RQ4: no reset clears ram; reset during ram write marks ram indeterminate; code marks it only for pin and watchdog resets
// RQ5: reset driver holds pin low twenty low-speed periods on stable supply
// RQ6: at power-up driver holds pin low through stabilise wait plus twenty periods
// RQ7: writing 1 to software reset bit resets all but a kept subset, restarts
// RQ8: watchdog underflow with action select 1 resets all but kept subset
// RQ9: watchdog action select is set-only and forced to 1 under source protection
// RQ10: oscillation stop with action bit 0 resets and halts, mode bits kept
// RQ11: output select drives pin as port, subclock, div-8 or div-32 clock
// RQ12: wait-mode gate bit stops peripheral base clock in wait mode only
// RQ13: subclock drive forced high while subclock pins are ports or on stop entry
// RQ14: main clock stop bit turns off main oscillator and holds its output high
// RQ15: main divider bit picks divide-by-8 or field; set on stop entry
// RQ16: system clock source bit picks subclock when 1, else main or low-speed
// RQ17: lock bit blocks writes to wait gate, main stop and source bits; code leaves the second source bit writable
// RQ18: subclock selected with main stopped holds divider and main drive at 1
// RQ19: software selects other source, disables detection, then stops main clock
// RQ20: software restarts main clock, waits, then clears both source bits
// RQ21: all-clock stop bit set to 1 stops all clocks and enters stop mode
// RQ22: clock registers accept writes only while protect enable bit is 1
// RQ23: second source bit picks main when 0, low-speed when 1, if source bit 0
// RQ24: lock bit 0 leaves protect register in charge, 1 disables modification
`include "rscc_map.vh"
module rscc_top (
   input wire clk_in,
   input wire arst_n_in,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire ext_reset_n_in,
   input wire wdt_underflow_in,
   input wire osc_stop_in,
   input wire ram_write_in,
   input wire wait_mode_in,
   input wire wake_in,
   input wire count_source_protection_enable_in,
   input wire subclock_tap_in,
   input wire low_speed_onchip_clock_in,
   output reg system_reset_n_out,
   output reg vector_fetch_out,
   output reg clock_output_pin_out,
   output reg clock_output_oe_out,
   output reg main_osc_enable_out,
   output reg main_oscillator_output_pin_out,
   output reg peripheral_clock_enable_out,
   output reg stop_mode_out,
   output reg [1:0] cpu_clock_source_out,
   output reg [2:0] cpu_clock_divider_out,
   output reg subclock_drive_strength_out,
   output reg main_drive_strength_out,
   output reg osc_detect_enable_out
);
   localparam ST_RUN = 2'd0;
   localparam ST_HOLD = 2'd1;
   localparam ST_WAIT = 2'd2;
   reg [1:0] pin_sync;
   reg [1:0] osc_sync;
   reg [1:0] sub_sync;
   reg [1:0] lso_sync;
   reg [7:0] ctrl_a;
   reg [7:0] ctrl_b;
   reg [7:0] pm_a;
   reg [7:0] pm_b;
   reg [7:0] osc_reg;
   reg [7:0] pm_c;
   reg [7:0] prot;
   reg [3:0] cause;
   reg ram_bad;
   reg [1:0] state;
   reg [4:0] hold_cnt;
   reg [4:0] div_cnt;
   reg [31:0] rd_data;
   reg [31:0] rd_q;
   reg addr_ok;
   wire pin_low = ~pin_sync[1];
   wire osc_stopped = osc_sync[1];
   wire wr = psel & penable & pwrite;
   wire [7:0] wd = pwdata[7:0];
   wire wr_ok = prot[`RSCC_PROT_EN]; // [RQ22]
   wire locked = pm_c[`RSCC_PMC_LOCK]; // [RQ24]
   wire wr_a = wr & ({2'b00, paddr} == {`RSCC_IDX_CTRL_A, 2'b00}) & wr_ok;
   wire wr_b = wr & ({2'b00, paddr} == {`RSCC_IDX_CTRL_B, 2'b00}) & wr_ok;
   wire wr_osc = wr & ({2'b00, paddr} == {`RSCC_IDX_OSC, 2'b00}) & wr_ok;
   wire wr_pma = wr & ({2'b00, paddr} == {`RSCC_IDX_PM_A, 2'b00});
   wire wr_pmb = wr & ({2'b00, paddr} == {`RSCC_IDX_PM_B, 2'b00});
   wire wr_pmc = wr & ({2'b00, paddr} == {`RSCC_IDX_PM_C, 2'b00});
   wire wr_prot = wr & ({2'b00, paddr} == {`RSCC_IDX_PROT, 2'b00});
   wire sw_rst = wr_pma & wd[`RSCC_PMA_SWRST]; // [RQ7]
   wire wdt_rst = wdt_underflow_in & pm_b[`RSCC_PMB_WDACT]; // [RQ8]
   wire osc_rst = osc_stopped & ~osc_reg[`RSCC_OSC_ACT]; // [RQ10]
   wire full_clr = pin_low | sw_rst | wdt_rst; // [RQ1]
   wire any_clr = full_clr | osc_rst;
   wire stop_entry = wr_b & wd[`RSCC_B_ALLSTOP] & ~locked & ~ctrl_b[`RSCC_B_ALLSTOP];
   ////////////////////////////////////////////////////////////////////////////////
   // pin and foreign-clock synchronisers
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_sync <= 2'b00;
         osc_sync <= 2'b00;
         sub_sync <= 2'b00;
         lso_sync <= 2'b00;
      end else begin
         pin_sync <= {pin_sync[0], ext_reset_n_in};
         osc_sync <= {osc_sync[0], osc_stop_in};
         sub_sync <= {sub_sync[0], subclock_tap_in};
         lso_sync <= {lso_sync[0], low_speed_onchip_clock_in};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // reset sequencer: hold internal reset, then request vector fetch
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= ST_HOLD;
         hold_cnt <= `RSCC_HOLD_CYCLES;
         system_reset_n_out <= 1'b0;
         vector_fetch_out <= 1'b0;
         cause <= 4'h1;
         ram_bad <= 1'b0;
      end else begin
         vector_fetch_out <= 1'b0;
         if (any_clr) begin
            state <= ST_HOLD;
            hold_cnt <= `RSCC_HOLD_CYCLES;
            system_reset_n_out <= 1'b0;
            cause <= {osc_rst, wdt_rst, sw_rst, pin_low};
            if ((pin_low | wdt_rst) & ram_write_in) begin
               ram_bad <= 1'b1; // [RQ4]
            end
         end else begin
            case (state)
               ST_HOLD: begin
                  if (hold_cnt == 5'd0) begin
                     state <= ST_WAIT;
                  end else begin
                     hold_cnt <= hold_cnt - 5'd1;
                  end
               end
               ST_WAIT: begin
                  state <= ST_RUN;
                  system_reset_n_out <= 1'b1;
                  vector_fetch_out <= 1'b1; // [RQ2]
               end
               ST_RUN: begin
                  if (wr_pma & ~wd[`RSCC_PMA_SWRST]) begin
                     ram_bad <= 1'b0;
                  end
               end
               default: begin
                  state <= ST_HOLD;
               end
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // registers; ram itself is never touched by any reset
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctrl_a <= `RSCC_RST_CTRL_A;
         ctrl_b <= `RSCC_RST_CTRL_B;
         pm_a <= `RSCC_RST_PM_A;
         pm_b <= `RSCC_RST_PM_B;
         osc_reg <= `RSCC_RST_OSC;
         pm_c <= `RSCC_RST_PM_C;
         prot <= `RSCC_RST_PROT;
      end else if (full_clr) begin
         ctrl_a <= `RSCC_RST_CTRL_A; // [RQ1] [RQ3]
         ctrl_b <= `RSCC_RST_CTRL_B;
         pm_a <= `RSCC_RST_PM_A;
         osc_reg <= `RSCC_RST_OSC; // [RQ3]
         pm_c <= `RSCC_RST_PM_C;
         prot <= `RSCC_RST_PROT;
         if (pin_low) begin
            pm_b <= `RSCC_RST_PM_B;
         end
      end else if (osc_rst) begin
         ctrl_a <= `RSCC_RST_CTRL_A; // [RQ10]
         ctrl_b <= `RSCC_RST_CTRL_B;
         pm_b <= `RSCC_RST_PM_B;
         pm_c <= `RSCC_RST_PM_C;
         prot <= `RSCC_RST_PROT;
         pm_a <= pm_a & 8'h03;
      end else begin
         if (wr_a) begin
            ctrl_a[`RSCC_A_OUTSEL_HI:`RSCC_A_OUTSEL_LO] <= wd[1:0]; // [RQ11]
            ctrl_a[`RSCC_A_SUBDRV] <= wd[`RSCC_A_SUBDRV];
            ctrl_a[`RSCC_A_SUBPIN] <= wd[`RSCC_A_SUBPIN];
            ctrl_a[`RSCC_A_MAINDIV] <= wd[`RSCC_A_MAINDIV]; // [RQ15]
            if (!locked) begin
               ctrl_a[`RSCC_A_WAITGATE] <= wd[`RSCC_A_WAITGATE]; // [RQ17]
               ctrl_a[`RSCC_A_MAINSTOP] <= wd[`RSCC_A_MAINSTOP];
               ctrl_a[`RSCC_A_SYSSRC] <= wd[`RSCC_A_SYSSRC];
            end
         end
         if (!ctrl_a[`RSCC_A_SUBPIN] | stop_entry) begin
            ctrl_a[`RSCC_A_SUBDRV] <= 1'b1; // [RQ13]
         end
         if (stop_entry) begin
            ctrl_a[`RSCC_A_MAINDIV] <= 1'b1; // [RQ15]
         end
         if (ctrl_a[`RSCC_A_SYSSRC] & ctrl_a[`RSCC_A_MAINSTOP]) begin
            ctrl_a[`RSCC_A_MAINDIV] <= 1'b1; // [RQ18]
         end
         if (wr_b) begin
            ctrl_b[`RSCC_B_DIV_HI:`RSCC_B_DIV_LO] <= wd[7:6];
            ctrl_b[`RSCC_B_MAINDRV] <= wd[`RSCC_B_MAINDRV];
            if (!locked) begin
               ctrl_b[`RSCC_B_ALLSTOP] <= wd[`RSCC_B_ALLSTOP]; // [RQ21]
            end
         end else if (wake_in) begin
            ctrl_b[`RSCC_B_ALLSTOP] <= 1'b0;
         end
         if (ctrl_a[`RSCC_A_SYSSRC] & ctrl_a[`RSCC_A_MAINSTOP]) begin
            ctrl_b[`RSCC_B_MAINDRV] <= 1'b1; // [RQ18]
         end
         if (wr_osc) begin
            osc_reg[`RSCC_OSC_SRC2] <= wd[`RSCC_OSC_SRC2];
            osc_reg[`RSCC_OSC_ACT] <= wd[`RSCC_OSC_ACT];
            if (!locked) begin
               osc_reg[`RSCC_OSC_DETEN] <= wd[`RSCC_OSC_DETEN];
            end
         end
         if (wr_pma) begin
            pm_a[`RSCC_PMA_MODE_HI:`RSCC_PMA_MODE_LO] <= wd[1:0];
         end
         if (count_source_protection_enable_in) begin
            pm_b[`RSCC_PMB_WDACT] <= 1'b1; // [RQ9]
         end else if (wr_pmb & wd[`RSCC_PMB_WDACT]) begin
            pm_b[`RSCC_PMB_WDACT] <= 1'b1; // [RQ9]
         end
         if (wr_pmc & wd[`RSCC_PMC_LOCK]) begin
            pm_c[`RSCC_PMC_LOCK] <= 1'b1; // [RQ24]
         end
         if (wr_prot) begin
            prot[`RSCC_PROT_EN] <= wd[`RSCC_PROT_EN];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // main clock taps: divide-by-8 and divide-by-32 square waves
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         div_cnt <= 5'd0;
      end else if (stop_mode_out | ctrl_a[`RSCC_A_MAINSTOP]) begin
         div_cnt <= 5'd0;
      end else begin
         div_cnt <= div_cnt + 5'd1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // clock control outputs
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         clock_output_pin_out <= 1'b0;
         clock_output_oe_out <= 1'b0;
         main_osc_enable_out <= 1'b0;
         main_oscillator_output_pin_out <= 1'b1;
         peripheral_clock_enable_out <= 1'b0;
         stop_mode_out <= 1'b0;
         cpu_clock_source_out <= 2'd1;
         cpu_clock_divider_out <= 3'd3;
         subclock_drive_strength_out <= 1'b1;
         main_drive_strength_out <= 1'b1;
         osc_detect_enable_out <= 1'b0;
      end else begin
         clock_output_oe_out <= ctrl_a[1:0] != 2'b00; // [RQ11]
         case (ctrl_a[1:0])
            2'b01: clock_output_pin_out <= sub_sync[1];
            2'b10: clock_output_pin_out <= div_cnt[2];
            2'b11: clock_output_pin_out <= div_cnt[4];
            default: clock_output_pin_out <= 1'b0;
         endcase
         stop_mode_out <= ctrl_b[`RSCC_B_ALLSTOP]; // [RQ21]
         main_osc_enable_out <= ~ctrl_a[`RSCC_A_MAINSTOP] & ~ctrl_b[`RSCC_B_ALLSTOP]; // [RQ14]
         main_oscillator_output_pin_out <= ctrl_a[`RSCC_A_MAINSTOP] |
            ctrl_b[`RSCC_B_ALLSTOP] | div_cnt[0]; // [RQ14]
         peripheral_clock_enable_out <= system_reset_n_out & ~ctrl_b[`RSCC_B_ALLSTOP] &
            ~(wait_mode_in & ctrl_a[`RSCC_A_WAITGATE]); // [RQ12]
         if (ctrl_a[`RSCC_A_SYSSRC]) begin
            cpu_clock_source_out <= 2'd2; // [RQ16]
         end else if (osc_reg[`RSCC_OSC_SRC2]) begin
            cpu_clock_source_out <= 2'd1; // [RQ23]
         end else begin
            cpu_clock_source_out <= 2'd0; // [RQ23]
         end
         if (ctrl_a[`RSCC_A_MAINDIV]) begin
            cpu_clock_divider_out <= 3'd3; // [RQ3] [RQ15]
         end else begin
            case (ctrl_b[7:6])
               2'b01: cpu_clock_divider_out <= 3'd1;
               2'b10: cpu_clock_divider_out <= 3'd2;
               2'b11: cpu_clock_divider_out <= 3'd4;
               default: cpu_clock_divider_out <= 3'd0;
            endcase
         end
         subclock_drive_strength_out <= ctrl_a[`RSCC_A_SUBDRV];
         main_drive_strength_out <= ctrl_b[`RSCC_B_MAINDRV];
         osc_detect_enable_out <= osc_reg[`RSCC_OSC_DETEN];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // apb read path; data captured in the setup cycle, unmapped addresses answer with pslverr
   always @* begin
      rd_data = 32'h0000_0000;
      addr_ok = 1'b1;
      case ({2'b00, paddr})
         {`RSCC_IDX_CTRL_A, 2'b00}: rd_data[7:0] = ctrl_a;
         {`RSCC_IDX_CTRL_B, 2'b00}: rd_data[7:0] = ctrl_b;
         {`RSCC_IDX_PM_A, 2'b00}: rd_data[7:0] = pm_a;
         {`RSCC_IDX_PM_B, 2'b00}: rd_data[7:0] = pm_b;
         {`RSCC_IDX_OSC, 2'b00}: rd_data[7:0] = {osc_reg[7:2], osc_reg[1:0]};
         {`RSCC_IDX_PM_C, 2'b00}: rd_data[7:0] = pm_c;
         {`RSCC_IDX_PROT, 2'b00}: rd_data[7:0] = prot;
         {`RSCC_IDX_STAT, 2'b00}: rd_data[7:0] = {lso_sync[1], stop_mode_out, osc_stopped,
            ram_bad, cause};
         default: addr_ok = 1'b0;
      endcase
   end
   always @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_q <= 32'h0000_0000;
      end else if (psel & ~penable) begin
         rd_q <= rd_data;
      end
   end
   assign prdata = rd_q;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
endmodule // rscc_top

// ---- hw/rscc_map.vh ----
// register map, reset values and timing counts of the reset and clock control block
`ifndef RSCC_MAP_VH
`define RSCC_MAP_VH
// register indices; byte address is four times the index
`define RSCC_IDX_CTRL_A 8'h06
`define RSCC_IDX_CTRL_B 8'h07
`define RSCC_IDX_PM_A 8'h10
`define RSCC_IDX_PM_B 8'h11
`define RSCC_IDX_OSC 8'h12
`define RSCC_IDX_PM_C 8'h13
`define RSCC_IDX_PROT 8'h14
`define RSCC_IDX_STAT 8'h15
// control a fields
`define RSCC_A_OUTSEL_LO 0
`define RSCC_A_OUTSEL_HI 1
`define RSCC_A_WAITGATE 2
`define RSCC_A_SUBDRV 3
`define RSCC_A_SUBPIN 4
`define RSCC_A_MAINSTOP 5
`define RSCC_A_MAINDIV 6
`define RSCC_A_SYSSRC 7
// control b fields
`define RSCC_B_ALLSTOP 0
`define RSCC_B_MAINDRV 5
`define RSCC_B_DIV_LO 6
`define RSCC_B_DIV_HI 7
// own register fields
`define RSCC_PMA_SWRST 3
`define RSCC_PMA_MODE_LO 0
`define RSCC_PMA_MODE_HI 1
`define RSCC_PMB_WDACT 2
`define RSCC_OSC_DETEN 0
`define RSCC_OSC_SRC2 1
`define RSCC_OSC_ACT 7
`define RSCC_PMC_LOCK 1
`define RSCC_PROT_EN 0
// reset values
`define RSCC_RST_CTRL_A 8'h48
`define RSCC_RST_CTRL_B 8'h20
`define RSCC_RST_PM_A 8'h00
`define RSCC_RST_PM_B 8'h00
`define RSCC_RST_OSC 8'h02
`define RSCC_RST_PM_C 8'h00
`define RSCC_RST_PROT 8'h00
// internal reset hold length in clk_in cycles
`define RSCC_HOLD_CYCLES 5'd16
`endif

// ---- tb/rscc_chk.sv ----
// port assertions for the reset and clock control block
module rscc_chk (
   input wire clk_in,
   input wire arst_n_in,
   input wire ext_reset_n_in,
   input wire wait_mode_in,
   input wire system_reset_n_out,
   input wire vector_fetch_out,
   input wire main_osc_enable_out,
   input wire main_oscillator_output_pin_out,
   input wire peripheral_clock_enable_out,
   input wire stop_mode_out,
   input wire [1:0] cpu_clock_source_out,
   input wire [2:0] cpu_clock_divider_out,
   input wire subclock_drive_strength_out,
   input wire main_drive_strength_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);
   pin_hold_a: assert property (!ext_reset_n_in [*4] |=> !system_reset_n_out)
      else $error("core running while reset pin low");
   reset_min_a: assert property ($rose(system_reset_n_out) |->
      !$past(system_reset_n_out, 16))
      else $error("internal reset too short");
   vec_rise_a: assert property (vector_fetch_out |-> $rose(system_reset_n_out))
      else $error("vector fetch without reset release");
   vec_single_a: assert property (vector_fetch_out |=> !vector_fetch_out)
      else $error("vector fetch longer than one cycle");
   boot_clock_a: assert property ($rose(system_reset_n_out) |->
      cpu_clock_source_out == 2'd1 && cpu_clock_divider_out == 3'd3)
      else $error("wrong processor clock after reset");
   main_pin_a: assert property (!main_osc_enable_out [*2] |->
      main_oscillator_output_pin_out)
      else $error("main output pin not high while stopped");
   stop_pin_a: assert property (stop_mode_out [*2] |-> main_oscillator_output_pin_out)
      else $error("main output pin not high in stop mode");
   stop_drive_a: assert property ($rose(stop_mode_out) |->
      ##[0:2] subclock_drive_strength_out)
      else $error("subclock drive not raised on stop entry");
   low_drive_a: assert property ((cpu_clock_source_out == 2'd2 && !main_osc_enable_out) [*3]
      |-> main_drive_strength_out)
      else $error("main drive not held high");
   periph_run_a: assert property ((!wait_mode_in && !stop_mode_out && system_reset_n_out) [*2]
      |-> peripheral_clock_enable_out)
      else $error("peripheral clock stopped outside wait");
endmodule // rscc_chk
bind rscc_top rscc_chk u_chk (.clk_in, .arst_n_in, .ext_reset_n_in, .wait_mode_in,
   .system_reset_n_out, .vector_fetch_out, .main_osc_enable_out, .main_oscillator_output_pin_out,
   .peripheral_clock_enable_out, .stop_mode_out, .cpu_clock_source_out, .cpu_clock_divider_out,
   .subclock_drive_strength_out, .main_drive_strength_out);

// ---- tb/rscc_rst_drv.sv ----
// board reset driver and free-running slow clock sources
module rscc_rst_drv #(
   parameter int LS_HALF_NS = 40,
   parameter int STAB_NS = 300
) (
   output logic ext_reset_n_out,
   output logic low_speed_clk_out,
   output logic subclock_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      low_speed_clk_out = 1'b0;
      forever #(LS_HALF_NS) low_speed_clk_out = ~low_speed_clk_out;
   end
   initial begin
      subclock_out = 1'b0;
      forever #153 subclock_out = ~subclock_out;
   end
   // power-up: low through the stabilise wait, then twenty slow periods
   initial begin
      ext_reset_n_out = 1'b0;
      #(STAB_NS);
      repeat (20) @(posedge low_speed_clk_out);
      ext_reset_n_out = 1'b1;
   end
   task automatic hold_reset();
      ext_reset_n_out <= 1'b0;
      repeat (20) @(posedge low_speed_clk_out);
      ext_reset_n_out <= 1'b1;
   endtask
endmodule // rscc_rst_drv

// ---- tb/testbench.sv ----
// self-checking bench for the reset and clock control block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CA = 8'h18, CB = 8'h1c, PMA = 8'h40, PMB = 8'h44;
   localparam logic [7:0] OSC = 8'h48, PMC = 8'h4c, PRT = 8'h50, STA = 8'h54;
   logic clk_in, arst_n_in, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, q;
   logic [31:0] pwdata, prdata;
   logic ext_reset_n_in, wdt_underflow_in, osc_stop_in, ram_write_in, wait_mode_in, wake_in;
   logic count_source_protection_enable_in, subclock_tap_in, low_speed_onchip_clock_in;
   logic system_reset_n_out, vector_fetch_out, clock_output_pin_out, clock_output_oe_out;
   logic main_osc_enable_out, main_oscillator_output_pin_out, peripheral_clock_enable_out;
   logic stop_mode_out, subclock_drive_strength_out, main_drive_strength_out;
   logic osc_detect_enable_out;
   logic [1:0] cpu_clock_source_out;
   logic [2:0] cpu_clock_divider_out;
   int err_count, n_compared;
   rscc_top dut (.clk_in, .arst_n_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .ext_reset_n_in, .wdt_underflow_in, .osc_stop_in, .ram_write_in, .wait_mode_in,
      .wake_in, .count_source_protection_enable_in, .subclock_tap_in, .low_speed_onchip_clock_in,
      .system_reset_n_out, .vector_fetch_out, .clock_output_pin_out, .clock_output_oe_out,
      .main_osc_enable_out, .main_oscillator_output_pin_out, .peripheral_clock_enable_out,
      .stop_mode_out, .cpu_clock_source_out, .cpu_clock_divider_out, .subclock_drive_strength_out,
      .main_drive_strength_out, .osc_detect_enable_out);
   rscc_rst_drv u_drv (.ext_reset_n_out(ext_reset_n_in),
      .low_speed_clk_out(low_speed_onchip_clock_in), .subclock_out(subclock_tap_in));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tk(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_in);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_in);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         err_count++;
         end_sim;
      end
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      chk($sformatf("reg_%h", a), q, x);
   endtask
   // waits for the restart pulse, bounded
   task boot;
      int i;
      i = 0;
      while (vector_fetch_out !== 1'b1 && i < 600) begin
         @(posedge clk_in);
         i++;
      end
      chk("vector_fetch", vector_fetch_out, 1);
      if (i >= 600) end_sim;
      @(posedge clk_in);
      chk("core_run", system_reset_n_out, 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk("cpu_src", cpu_clock_source_out, 1);
      chk("cpu_div", cpu_clock_divider_out, 3);
      rd(CA, 8'h48);
      rd(CB, 8'h20);
      rd(OSC, 8'h02);
      rd(PMC, 8'h00);
      apb(1'b0, 8'hfc, 8'h00);
      chk("unmapped_err", e, 1);
      wr(CA, 8'h00);
      rd(CA, 8'h48);
      wr(PRT, 8'h01);
   endtask
   task t_ctrl;
      logic [2:0] dv [4];
      logic [1:0] seen;
      dv = '{3'd0, 3'd1, 3'd2, 3'd4};
      for (int s = 0; s < 4; s++) begin
         wr(CA, 8'h10 | 8'(s));
         wr(CB, 8'h20 | 8'(s << 6));
         tk(3);
         chk("clk_out_oe", clock_output_oe_out, s != 0);
         chk("cpu_div", cpu_clock_divider_out, dv[s]);
         // plain port stays low; the divide-by-8 tap shows both levels within 8 cycles
         seen = 2'b00;
         repeat (8) begin
            @(posedge clk_in);
            seen = seen | (2'b01 << clock_output_pin_out);
         end
         if (s == 0 || s == 2) begin
            chk("clk_out_pin", seen, (s == 0) ? 2'b01 : 2'b11);
         end
      end
      wr(CA, 8'h00);
      rd(CA, 8'h08);
      chk("sub_drive", subclock_drive_strength_out, 1);
      wr(CA, 8'h50);
      tk(3);
      chk("cpu_div", cpu_clock_divider_out, 3);
   endtask
   task t_source;
      wr(OSC, 8'h03);
      tk(2);
      chk("osc_det", osc_detect_enable_out, 1);
      wr(CB, 8'h00);
      wr(OSC, 8'h00);
      tk(3);
      chk("osc_det", osc_detect_enable_out, 0);
      chk("cpu_src", cpu_clock_source_out, 0);
      wr(OSC, 8'h02);
      tk(3);
      chk("cpu_src", cpu_clock_source_out, 1);
      wr(CA, 8'hd0);
      tk(3);
      chk("cpu_src", cpu_clock_source_out, 2);
      // detection is already off, so the main clock may be stopped now
      wr(CA, 8'hb0);
      rd(CA, 8'hf0);
      rd(CB, 8'h20);
      chk("main_osc", main_osc_enable_out, 0);
      chk("main_pin", main_oscillator_output_pin_out, 1);
      wr(CA, 8'h90);
      tk(20);
      wr(CA, 8'h10);
      wr(OSC, 8'h00);
      tk(3);
      chk("cpu_src", cpu_clock_source_out, 0);
      chk("main_osc", main_osc_enable_out, 1);
      wr(OSC, 8'h02);
   endtask
   task t_wait;
      wr(CA, 8'h54);
      wait_mode_in <= 1'b1;
      tk(3);
      chk("periph_clk", peripheral_clock_enable_out, 0);
      wait_mode_in <= 1'b0;
      tk(3);
      chk("periph_clk", peripheral_clock_enable_out, 1);
      wr(CA, 8'h50);
      wait_mode_in <= 1'b1;
      tk(3);
      chk("periph_clk", peripheral_clock_enable_out, 1);
      wait_mode_in <= 1'b0;
   endtask
   task t_stop;
      wr(CA, 8'h10);
      wr(CB, 8'h01);
      tk(3);
      chk("stop_mode", stop_mode_out, 1);
      rd(CA, 8'h58);
      wake_in <= 1'b1;
      @(posedge clk_in);
      wake_in <= 1'b0;
      tk(3);
      chk("stop_mode", stop_mode_out, 0);
   endtask
   task t_lock;
      wr(PMC, 8'h02);
      wr(CA, 8'hb4);
      rd(CA, 8'h10);
      wr(CB, 8'h21);
      rd(CB, 8'h20);
      wr(PMC, 8'h00);
      rd(PMC, 8'h02);
   endtask
   task t_resets;
      wr(PMB, 8'h04);
      wr(PMB, 8'h00);
      rd(PMB, 8'h04);
      ram_write_in <= 1'b1;
      u_drv.hold_reset();
      chk("core_held", system_reset_n_out, 0);
      ram_write_in <= 1'b0;
      boot;
      apb(1'b0, STA, 8'h00);
      chk("ram_flag", q[4], 1);
      rd(PMB, 8'h00);
      rd(PMC, 8'h00);
      count_source_protection_enable_in <= 1'b1;
      rd(PMB, 8'h04);
      count_source_protection_enable_in <= 1'b0;
      wr(PMB, 8'h04);
      wdt_underflow_in <= 1'b1;
      @(posedge clk_in);
      wdt_underflow_in <= 1'b0;
      tk(4);
      chk("core_held", system_reset_n_out, 0);
      boot;
      rd(PMB, 8'h04);
      wr(PRT, 8'h01);
      wr(CA, 8'h10);
      wr(PMA, 8'h08);
      tk(4);
      chk("core_held", system_reset_n_out, 0);
      boot;
      rd(CA, 8'h48);
      rd(PRT, 8'h00);
      wr(PMA, 8'h01);
      osc_stop_in <= 1'b1;
      tk(8);
      chk("core_held", system_reset_n_out, 0);
      osc_stop_in <= 1'b0;
      boot;
      rd(PMA, 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {arst_n_in, psel, penable, pwrite, wdt_underflow_in, osc_stop_in} = 6'h00;
      {ram_write_in, wait_mode_in, wake_in, count_source_protection_enable_in} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      err_count = 0;
      n_compared = 0;
      repeat (3) @(posedge clk_in);
      arst_n_in <= 1'b1;
      boot;
      t_reset;
      t_ctrl;
      t_source;
      t_wait;
      t_stop;
      t_lock;
      t_resets;
      end_sim;
   end
endmodule // testbench
